// [bmp_pkg.sv]
// shared constants and types for the four burst memory ports
package bmp_pkg;
  localparam int NPORT = 4;
  localparam int PW = 2;
  localparam int AW = 16;
  localparam int DW = 18;
  localparam int BW = 9;
  localparam int LANES = 2;
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
  localparam logic [AW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [AW-1:0] CNT_ONE = 16'h0001;
  localparam logic [AW-1:0] CNT_LAST = 16'hffff;
  localparam logic [AW-1:0] MASK_RST = 16'hffff;
  localparam logic [DW-1:0] DATA_ZERO = 18'h00000;
  localparam int HOST_RST_CYCLES = 4;
  localparam int RCNT_W = 16;

  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_READ = 3'h1,
    OP_LOAD = 3'h2,
    OP_STEP = 3'h3,
    OP_CLEAR = 3'h4,
    OP_MASK = 3'h5,
    OP_READBACK = 3'h6
  } bmp_op_t;

  typedef enum logic [1:0] {
    HS_RESET = 2'h0,
    HS_IDLE = 2'h1,
    HS_DRIVE = 2'h2,
    HS_HOLD = 2'h3
  } bmp_hstate_t;
endpackage

// [bmp_port_if.sv]
// pin bundle of all four memory ports, with bus resolution
`timescale 1ns/1ps
interface bmp_port_if;
  logic global_reset_n;
  logic [bmp_pkg::NPORT-1:0] low_byte_select_n;
  logic [bmp_pkg::NPORT-1:0] high_byte_select_n;
  logic [bmp_pkg::NPORT-1:0] port_select_low_n;
  logic [bmp_pkg::NPORT-1:0] port_select_high;
  logic [bmp_pkg::NPORT-1:0] out_en_n;
  logic [bmp_pkg::NPORT-1:0] rd_wr;
  logic [bmp_pkg::NPORT-1:0] burst_counter_clear_n;
  logic [bmp_pkg::NPORT-1:0] wrap_mask_load_n;
  logic [bmp_pkg::NPORT-1:0] burst_counter_load_n;
  logic [bmp_pkg::NPORT-1:0] burst_counter_step_n;
  logic [bmp_pkg::NPORT-1:0] burst_counter_readback_n;
  logic [bmp_pkg::NPORT-1:0] counter_wrap_flag_n;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::AW-1:0] host_addr_o;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::AW-1:0] dev_addr_o;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::AW-1:0] addr;
  logic [bmp_pkg::NPORT-1:0] host_addr_oe;
  logic [bmp_pkg::NPORT-1:0] dev_addr_oe;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::DW-1:0] host_dq_o;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::DW-1:0] dev_dq_o;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::DW-1:0] dq;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::LANES-1:0] host_dq_oe;
  logic [bmp_pkg::NPORT-1:0][bmp_pkg::LANES-1:0] dev_dq_oe;

  // undriven wires read as zero; device drive wins a clash
  genvar p, b;
  generate
    for (p = 0; p < bmp_pkg::NPORT; p++) begin : g_p
      assign addr[p] = dev_addr_oe[p] ? dev_addr_o[p] :
                       host_addr_oe[p] ? host_addr_o[p] : bmp_pkg::CNT_ZERO;
      for (b = 0; b < bmp_pkg::LANES; b++) begin : g_b
        assign dq[p][b*bmp_pkg::BW +: bmp_pkg::BW] =
          dev_dq_oe[p][b] ? dev_dq_o[p][b*bmp_pkg::BW +: bmp_pkg::BW] :
          host_dq_oe[p][b] ? host_dq_o[p][b*bmp_pkg::BW +: bmp_pkg::BW] :
          bmp_pkg::DATA_ZERO[bmp_pkg::BW-1:0];
      end
    end
  endgenerate

  modport device (
    input global_reset_n, low_byte_select_n, high_byte_select_n,
    input port_select_low_n, port_select_high, out_en_n, rd_wr,
    input burst_counter_clear_n, wrap_mask_load_n, burst_counter_load_n,
    input burst_counter_step_n, burst_counter_readback_n, addr, dq,
    output counter_wrap_flag_n, dev_addr_o, dev_addr_oe, dev_dq_o, dev_dq_oe
  );
  modport host (
    output global_reset_n, low_byte_select_n, high_byte_select_n,
    output port_select_low_n, port_select_high, out_en_n, rd_wr,
    output burst_counter_clear_n, wrap_mask_load_n, burst_counter_load_n,
    output burst_counter_step_n, burst_counter_readback_n,
    output host_addr_o, host_addr_oe, host_dq_o, host_dq_oe,
    input counter_wrap_flag_n, addr, dq
  );
endinterface // bmp_port_if

// [bmp_dev_end.sv]
// device end: four burst memory ports over one shared array
`timescale 1ns/1ps
// Operation
// - low byte select gates low byte access
// - low byte driven only with select and enable
// - high byte select mirrors low byte select
// - port selected when both enables active
// - output enable low drives data, asynchronously
// - host drives read/write low to write
// - shared async master reset resets all port registers, not the array
// - host applies master reset after power-up
// - counter clear input zeroes burst counter
// - clear beats all but master reset
// - mask load captures address lines
// - mask load wins over counter load
// - counter load takes address pins
// - step input advances counter every edge that clear, mask load and counter load are idle
// - works with free or strobed clock
// - readback puts counter on address, data off when port selected
// - wrap to zero pulses flag one cycle
module bmp_dev_end #(
  parameter int MEM_AW = bmp_pkg::AW
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // memory port pins
  bmp_port_if.device bus,
  // user side status
  output logic [bmp_pkg::NPORT-1:0] wrap_pulse,
  output logic [bmp_pkg::NPORT-1:0][bmp_pkg::AW-1:0] burst_count
);
  // ------------------------------------------------------------
  // reset and shared storage
  // ------------------------------------------------------------
  logic arst_n;
  logic [bmp_pkg::DW-1:0] mem [2**MEM_AW];
  logic [bmp_pkg::NPORT-1:0][MEM_AW-1:0] waddr;
  logic [bmp_pkg::NPORT-1:0] wr_lo;
  logic [bmp_pkg::NPORT-1:0] wr_hi;

  assign arst_n = rstn & bus.global_reset_n;

  // ------------------------------------------------------------
  // per-port control
  // ------------------------------------------------------------
  // one identical slice per port
  genvar p;
  generate
    for (p = 0; p < bmp_pkg::NPORT; p++) begin : g_port
      logic [bmp_pkg::AW-1:0] cnt_r;
      logic [bmp_pkg::AW-1:0] cnt_nxt;
      logic [bmp_pkg::AW-1:0] mask_r;
      logic [bmp_pkg::AW-1:0] mask_nxt;
      logic [bmp_pkg::DW-1:0] rdat_r;
      logic [bmp_pkg::DW-1:0] rdat_nxt;
      logic [bmp_pkg::AW-1:0] acc_addr;
      logic wrap_r;
      logic wrap_nxt;
      logic rdv_r;
      logic rdv_nxt;
      logic sel;
      logic rb;
      logic wr;

      assign sel = ~bus.port_select_low_n[p] & bus.port_select_high[p];
      // readback only with load and step idle
      assign rb = ~bus.burst_counter_readback_n[p] &
                  bus.burst_counter_load_n[p] & bus.burst_counter_step_n[p];
      // a load cycle accesses the presented address directly
      assign acc_addr = bus.burst_counter_load_n[p] ? cnt_r : bus.addr[p];
      assign wr = sel & ~bus.rd_wr[p] & ~rb;
      assign waddr[p] = acc_addr[MEM_AW-1:0];
      assign wr_lo[p] = wr & ~bus.low_byte_select_n[p];
      assign wr_hi[p] = wr & ~bus.high_byte_select_n[p];

      always_comb begin
        cnt_nxt = cnt_r;
        mask_nxt = mask_r;
        wrap_nxt = 1'b0;
        // clear first, then mask, load, step
        if (!bus.burst_counter_clear_n[p]) begin
          cnt_nxt = bmp_pkg::CNT_ZERO;
        end else if (!bus.wrap_mask_load_n[p]) begin
          mask_nxt = bus.addr[p];
        end else if (!bus.burst_counter_load_n[p]) begin
          cnt_nxt = bus.addr[p];
        end else if (!bus.burst_counter_step_n[p]) begin
          cnt_nxt = cnt_r + bmp_pkg::CNT_ONE;
          wrap_nxt = (cnt_r == bmp_pkg::CNT_LAST);
        end
        rdv_nxt = sel & bus.rd_wr[p] & ~rb;
        rdat_nxt = rdv_nxt ? mem[acc_addr[MEM_AW-1:0]] : rdat_r;
      end

      // state only moves on edges, so strobed clocks are safe
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_r <= bmp_pkg::CNT_ZERO;
          mask_r <= bmp_pkg::MASK_RST;
          rdat_r <= bmp_pkg::DATA_ZERO;
          wrap_r <= 1'b0;
          rdv_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          mask_r <= mask_nxt;
          rdat_r <= rdat_nxt;
          wrap_r <= wrap_nxt;
          rdv_r <= rdv_nxt;
        end
      end

      assign bus.counter_wrap_flag_n[p] = ~wrap_r;
      assign wrap_pulse[p] = wrap_r;
      assign burst_count[p] = cnt_r;
      assign bus.dev_addr_oe[p] = rb;
      assign bus.dev_addr_o[p] = cnt_r;
      assign bus.dev_dq_o[p] = rdat_r;
      // low lane needs select and enable, no clock wait
      // enable acts combinationally on the drivers
      // readback with port selected keeps data off
      assign bus.dev_dq_oe[p][bmp_pkg::LANE_LO] = rdv_r & ~bus.out_en_n[p] &
        ~bus.low_byte_select_n[p] & ~(rb & sel);
      // high lane gated the same way
      assign bus.dev_dq_oe[p][bmp_pkg::LANE_HI] = rdv_r & ~bus.out_en_n[p] &
        ~bus.high_byte_select_n[p] & ~(rb & sel);
    end
  endgenerate

  // ------------------------------------------------------------
  // array write
  // ------------------------------------------------------------
  // same-word writes from two ports are undefined; higher index lands last
  // array is not reset, so it holds no control state
  always_ff @(posedge mclk) begin
    for (int i = 0; i < bmp_pkg::NPORT; i++) begin
      // low byte written only when selected
      if (wr_lo[i]) begin
        mem[waddr[i]][bmp_pkg::BW-1:0] <= bus.dq[i][bmp_pkg::BW-1:0];
      end
      if (wr_hi[i]) begin
        mem[waddr[i]][bmp_pkg::DW-1:bmp_pkg::BW] <= bus.dq[i][bmp_pkg::DW-1:bmp_pkg::BW];
      end
    end
  end
endmodule // bmp_dev_end

// [bmp_host_end.sv]
// host end: sequences single commands onto one memory port at a time
`timescale 1ns/1ps
module bmp_host_end #(
  parameter int RST_CYCLES = bmp_pkg::HOST_RST_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // memory port pins
  bmp_port_if.host bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bmp_pkg::bmp_op_t cmd_op,
  input wire logic [bmp_pkg::PW-1:0] cmd_port,
  input wire logic [bmp_pkg::AW-1:0] cmd_addr,
  input wire logic [bmp_pkg::DW-1:0] cmd_data,
  input wire logic [bmp_pkg::LANES-1:0] cmd_bytes,
  // response
  output logic rsp_valid,
  output logic [bmp_pkg::DW-1:0] rsp_data,
  output logic [bmp_pkg::NPORT-1:0] wrap_seen
);
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  bmp_pkg::bmp_hstate_t st_r, st_nxt;
  bmp_pkg::bmp_op_t op_r, op_nxt;
  logic [bmp_pkg::PW-1:0] port_r, port_nxt;
  logic [bmp_pkg::AW-1:0] addr_r, addr_nxt;
  logic [bmp_pkg::DW-1:0] data_r, data_nxt;
  logic [bmp_pkg::LANES-1:0] bytes_r, bytes_nxt;
  logic [bmp_pkg::DW-1:0] rsp_data_r, rsp_data_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [bmp_pkg::RCNT_W-1:0] rcnt_r, rcnt_nxt;
  logic grst_r, grst_nxt;
  logic [bmp_pkg::NPORT-1:0] wrap_r, wrap_nxt;

  assign cmd_ready = (st_r == bmp_pkg::HS_IDLE);

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    port_nxt = port_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    bytes_nxt = bytes_r;
    rsp_data_nxt = rsp_data_r;
    rsp_valid_nxt = 1'b0;
    rcnt_nxt = rcnt_r;
    grst_nxt = grst_r;
    wrap_nxt = ~bus.counter_wrap_flag_n;
    unique case (st_r)
      // hold master reset low after power-up
      bmp_pkg::HS_RESET: begin
        rcnt_nxt = rcnt_r + 1'b1;
        if (rcnt_r == bmp_pkg::RCNT_W'(RST_CYCLES - 1)) begin
          grst_nxt = 1'b1;
          st_nxt = bmp_pkg::HS_IDLE;
        end
      end
      bmp_pkg::HS_IDLE: begin
        if (cmd_valid) begin
          op_nxt = cmd_op;
          port_nxt = cmd_port;
          addr_nxt = cmd_addr;
          data_nxt = cmd_data;
          bytes_nxt = cmd_bytes;
          st_nxt = bmp_pkg::HS_DRIVE;
        end
      end
      bmp_pkg::HS_DRIVE: begin
        if (op_r == bmp_pkg::OP_READ || op_r == bmp_pkg::OP_READBACK) begin
          st_nxt = bmp_pkg::HS_HOLD;
        end else begin
          st_nxt = bmp_pkg::HS_IDLE;
        end
      end
      bmp_pkg::HS_HOLD: begin
        // device data is registered, so it shows one cycle later
        rsp_valid_nxt = 1'b1;
        rsp_data_nxt = (op_r == bmp_pkg::OP_READ) ? bus.dq[port_r] :
                       bmp_pkg::DW'(bus.addr[port_r]);
        st_nxt = bmp_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= bmp_pkg::HS_RESET;
      op_r <= bmp_pkg::OP_WRITE;
      port_r <= '0;
      addr_r <= bmp_pkg::CNT_ZERO;
      data_r <= bmp_pkg::DATA_ZERO;
      bytes_r <= '0;
      rsp_data_r <= bmp_pkg::DATA_ZERO;
      rsp_valid_r <= 1'b0;
      rcnt_r <= '0;
      grst_r <= 1'b0;
      wrap_r <= '0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      port_r <= port_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      bytes_r <= bytes_nxt;
      rsp_data_r <= rsp_data_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rcnt_r <= rcnt_nxt;
      grst_r <= grst_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign wrap_seen = wrap_r;
  assign bus.global_reset_n = grst_r;

  // ------------------------------------------------------------
  // pin decode, all from registered command fields
  // ------------------------------------------------------------
  logic drv;
  logic busy;
  logic is_acc;
  assign drv = (st_r == bmp_pkg::HS_DRIVE);
  assign busy = drv | (st_r == bmp_pkg::HS_HOLD);
  assign is_acc = (op_r == bmp_pkg::OP_WRITE) | (op_r == bmp_pkg::OP_READ);

  genvar p;
  generate
    for (p = 0; p < bmp_pkg::NPORT; p++) begin : g_pin
      logic act;
      logic hit;
      assign hit = (port_r == bmp_pkg::PW'(p));
      assign act = hit & busy;
      // select only on the access cycle
      assign bus.port_select_low_n[p] = ~(hit & drv & is_acc);
      assign bus.port_select_high[p] = hit & drv & is_acc;
      assign bus.rd_wr[p] = ~(hit & drv & (op_r == bmp_pkg::OP_WRITE));
      // enable kept low through the read hold
      assign bus.out_en_n[p] = ~(act & (op_r == bmp_pkg::OP_READ));
      assign bus.low_byte_select_n[p] = ~(act & is_acc & bytes_r[bmp_pkg::LANE_LO]);
      assign bus.high_byte_select_n[p] = ~(act & is_acc & bytes_r[bmp_pkg::LANE_HI]);
      // accesses load the counter so the address applies directly;
      // clear and mask cycles pull load too, so the device priority gets exercised
      assign bus.burst_counter_load_n[p] = ~(hit & drv & (is_acc |
        (op_r == bmp_pkg::OP_LOAD) | (op_r == bmp_pkg::OP_CLEAR) | (op_r == bmp_pkg::OP_MASK)));
      assign bus.burst_counter_step_n[p] = ~(hit & drv & (op_r == bmp_pkg::OP_STEP));
      assign bus.burst_counter_clear_n[p] = ~(hit & drv & (op_r == bmp_pkg::OP_CLEAR));
      assign bus.wrap_mask_load_n[p] = ~(hit & drv & (op_r == bmp_pkg::OP_MASK));
      // readback held with load and step high
      assign bus.burst_counter_readback_n[p] = ~(act & (op_r == bmp_pkg::OP_READBACK));
      assign bus.host_addr_oe[p] = act & (op_r != bmp_pkg::OP_READBACK);
      assign bus.host_addr_o[p] = addr_r;
      assign bus.host_dq_o[p] = data_r;
      assign bus.host_dq_oe[p] = (hit & drv & (op_r == bmp_pkg::OP_WRITE)) ? bytes_r : '0;
    end
  endgenerate
endmodule // bmp_host_end

// [bmp_port_sva.sv]
// concurrent checks on the pin bundle between the host and device ends
`timescale 1ns/1ps
module bmp_port_sva #(
  parameter int N = bmp_pkg::NPORT,
  parameter int A = bmp_pkg::AW
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host driven pins
  input wire logic global_reset_n,
  input wire logic [N-1:0] low_byte_select_n,
  input wire logic [N-1:0] high_byte_select_n,
  input wire logic [N-1:0] port_select_low_n,
  input wire logic [N-1:0] port_select_high,
  input wire logic [N-1:0] out_en_n,
  input wire logic [N-1:0] rd_wr,
  input wire logic [N-1:0] burst_counter_clear_n,
  input wire logic [N-1:0] wrap_mask_load_n,
  input wire logic [N-1:0] burst_counter_load_n,
  input wire logic [N-1:0] burst_counter_step_n,
  input wire logic [N-1:0] burst_counter_readback_n,
  input wire logic [N-1:0][A-1:0] addr,
  // device driven pins
  input wire logic [N-1:0] counter_wrap_flag_n,
  input wire logic [N-1:0][A-1:0] dev_addr_o,
  input wire logic [N-1:0] dev_addr_oe,
  input wire logic [N-1:0][bmp_pkg::LANES-1:0] dev_dq_oe
);
  logic [N-1:0][A-1:0] cnt_r;
  logic [N-1:0][A-1:0] cnt_nxt;
  logic [N-1:0] wrap_c;
  logic [N-1:0] rb_c;
  logic [N-1:0] sel_c;

  // ----------------------------------------
  // shadow counters
  // ----------------------------------------
  // same priority as the device, so readback can be judged exactly
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cnt_nxt[i] = cnt_r[i];
      if (!global_reset_n || !burst_counter_clear_n[i]) begin
        cnt_nxt[i] = bmp_pkg::CNT_ZERO;
      end else if (!wrap_mask_load_n[i]) begin
        cnt_nxt[i] = cnt_r[i];
      end else if (!burst_counter_load_n[i]) begin
        cnt_nxt[i] = addr[i];
      end else if (!burst_counter_step_n[i]) begin
        cnt_nxt[i] = cnt_r[i] + bmp_pkg::CNT_ONE;
      end
      wrap_c[i] = global_reset_n && burst_counter_clear_n[i] && wrap_mask_load_n[i] &&
                  burst_counter_load_n[i] && !burst_counter_step_n[i] &&
                  cnt_r[i] == bmp_pkg::CNT_LAST;
      rb_c[i] = !burst_counter_readback_n[i] && burst_counter_load_n[i] &&
                burst_counter_step_n[i];
      sel_c[i] = !port_select_low_n[i] && port_select_high[i];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= {N{bmp_pkg::CNT_ZERO}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // assertions per port
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  for (genvar p = 0; p < N; p++) begin : g_chk
    property p_rb_addr;
      rb_c[p] |-> dev_addr_oe[p] && dev_addr_o[p] == cnt_r[p];
    endproperty
    a_rb_addr: assert property (p_rb_addr) else $error("readback address wrong");
    property p_rb_data;
      rb_c[p] && sel_c[p] |-> dev_dq_oe[p] == 2'h0;
    endproperty
    a_rb_data: assert property (p_rb_data) else $error("data driven in readback");
    property p_lane_lo;
      dev_dq_oe[p][0] |-> !low_byte_select_n[p] && !out_en_n[p] && global_reset_n;
    endproperty
    a_lane_lo: assert property (p_lane_lo) else $error("low lane driven wrongly");
    property p_lane_hi;
      dev_dq_oe[p][1] |-> !high_byte_select_n[p] && !out_en_n[p] && global_reset_n;
    endproperty
    a_lane_hi: assert property (p_lane_hi) else $error("high lane driven wrongly");
    // data is registered, so drive is only owed the cycle after a read access
    property p_oe_on;
      $past(sel_c[p] && rd_wr[p] && !rb_c[p] && global_reset_n) && !out_en_n[p] &&
        !low_byte_select_n[p] && burst_counter_readback_n[p] && global_reset_n |->
        dev_dq_oe[p][0];
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("low lane not driven");
    property p_oe_on_hi;
      $past(sel_c[p] && rd_wr[p] && !rb_c[p] && global_reset_n) && !out_en_n[p] &&
        !high_byte_select_n[p] && burst_counter_readback_n[p] && global_reset_n |->
        dev_dq_oe[p][1];
    endproperty
    a_oe_on_hi: assert property (p_oe_on_hi) else $error("high lane not driven");
    property p_wrap;
      wrap_c[p] |=> !counter_wrap_flag_n[p] ##1 counter_wrap_flag_n[p];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag pulse wrong");
    property p_flag_cause;
      !counter_wrap_flag_n[p] |-> $past(wrap_c[p]);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("wrap flag without wrap");
    property p_grst;
      !global_reset_n |-> counter_wrap_flag_n[p] && !dev_addr_oe[p] && dev_dq_oe[p] == 2'h0;
    endproperty
    a_grst: assert property (p_grst) else $error("device active in reset");
  end
endmodule // bmp_port_sva

// [test_burst_memory_port_control.sv]
// self-checking bench: host end and device end joined by the pin bundle
`timescale 1ns/1ps
module test_burst_memory_port_control;
  localparam int N = bmp_pkg::NPORT;
  localparam int LIMIT = 5000;
  logic mclk;
  logic rstn;
  logic cmd_valid;
  logic cmd_ready;
  bmp_pkg::bmp_op_t cmd_op;
  logic [1:0] cmd_port;
  logic [15:0] cmd_addr;
  logic [17:0] cmd_data;
  logic [1:0] cmd_bytes;
  logic rsp_valid;
  logic [17:0] rsp_data;
  logic [N-1:0] wrap_seen;
  logic [N-1:0] wrap_pulse;
  logic [N-1:0][15:0] burst_count;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int gcnt = 0;
  int wraps[N];
  int pulses[N];

  bmp_port_if bus ();
  bmp_host_end bmp_host_end_i (.mclk(mclk), .rstn(rstn), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_port(cmd_port), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_bytes(cmd_bytes), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .wrap_seen(wrap_seen));
  // small array keeps the run short; counters stay full width
  bmp_dev_end #(.MEM_AW(4)) bmp_dev_end_i (.mclk(mclk), .rstn(rstn), .bus(bus),
    .wrap_pulse(wrap_pulse), .burst_count(burst_count));
  bmp_port_sva bmp_port_sva_i (.mclk(mclk), .rstn(rstn),
    .global_reset_n(bus.global_reset_n), .low_byte_select_n(bus.low_byte_select_n),
    .high_byte_select_n(bus.high_byte_select_n), .port_select_low_n(bus.port_select_low_n),
    .port_select_high(bus.port_select_high), .out_en_n(bus.out_en_n),
    .rd_wr(bus.rd_wr),
    .burst_counter_clear_n(bus.burst_counter_clear_n), .wrap_mask_load_n(bus.wrap_mask_load_n),
    .burst_counter_load_n(bus.burst_counter_load_n),
    .burst_counter_step_n(bus.burst_counter_step_n),
    .burst_counter_readback_n(bus.burst_counter_readback_n), .addr(bus.addr),
    .counter_wrap_flag_n(bus.counter_wrap_flag_n), .dev_addr_o(bus.dev_addr_o),
    .dev_addr_oe(bus.dev_addr_oe), .dev_dq_oe(bus.dev_dq_oe));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------
  // monitors and tasks
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (rstn === 1'b1 && bus.global_reset_n === 1'b0) begin
      gcnt++;
    end
    for (int i = 0; i < N; i++) begin
      if (wrap_seen[i] === 1'b1) begin
        wraps[i]++;
      end
      if (wrap_pulse[i] === 1'b1) begin
        pulses[i]++;
      end
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // offer one command and hold it until the edge that takes it
  task automatic issue(input bmp_pkg::bmp_op_t op, input logic [1:0] p,
                       input logic [15:0] a, input logic [17:0] d, input logic [1:0] b);
    int n;
    n = 0;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_port <= p;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_bytes <= b;
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40);
    cmd_valid <= 1'b0;
    if (cmd_ready !== 1'b1) begin
      error_cnt++;
      $display("BAD t=%0t command not taken got=%h exp=%h", $time, cmd_ready, 1'b1);
    end
  endtask

  task automatic wait_rsp();
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    if (rsp_valid !== 1'b1) begin
      error_cnt++;
      $display("BAD t=%0t no response got=%h exp=%h", $time, rsp_valid, 1'b1);
    end
  endtask

  task automatic rd(input logic [1:0] p, input logic [15:0] a, input logic [1:0] b,
                    input logic [17:0] exp);
    issue(bmp_pkg::OP_READ, p, a, 18'h00000, b);
    wait_rsp();
    chk_data(rsp_data, exp);
  endtask

  task automatic rdback(input logic [1:0] p, input logic [15:0] exp);
    issue(bmp_pkg::OP_READBACK, p, 16'h0000, 18'h00000, 2'h0);
    wait_rsp();
    chk_data(rsp_data, {2'h0, exp});
    chk_cnt(burst_count[p], exp);
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    logic [17:0] w;
    logic [15:0] a;
    int n;
    int m;
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = bmp_pkg::OP_WRITE;
    cmd_port = 2'h0;
    cmd_addr = 16'h0000;
    cmd_data = 18'h00000;
    cmd_bytes = 2'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    for (int p = 0; p < N; p++) begin
      rdback(p[1:0], 16'h0000);
    end
    chk_cnt(16'(gcnt), 16'(bmp_pkg::HOST_RST_CYCLES));
    $display("test reset done");
    for (int p = 0; p < N; p++) begin
      a = 16'(p * 3 + 1);
      w = 18'h2a5c3 ^ 18'(p * 4369);
      issue(bmp_pkg::OP_WRITE, p[1:0], a, w, 2'h3);
      rd(p[1:0], a, 2'h3, w);
      rd(p[1:0], a, 2'h1, {9'h000, w[8:0]});
      rd(p[1:0], a, 2'h2, {w[17:9], 9'h000});
      issue(bmp_pkg::OP_WRITE, p[1:0], a, ~w, 2'h1);
      rd(p[1:0], a, 2'h3, {w[17:9], ~w[8:0]});
      rd(2'(p + 1), a, 2'h3, {w[17:9], ~w[8:0]});
    end
    $display("test data lanes done");
    for (int p = 0; p < N; p++) begin
      issue(bmp_pkg::OP_LOAD, p[1:0], 16'h1230 + 16'(p), 18'h00000, 2'h0);
      repeat (3) issue(bmp_pkg::OP_STEP, p[1:0], 16'h0000, 18'h00000, 2'h0);
    end
    for (int p = 0; p < N; p++) begin
      rdback(p[1:0], 16'h1233 + 16'(p));
    end
    $display("test counter steps done");
    for (int p = 0; p < N; p++) begin
      issue(bmp_pkg::OP_LOAD, p[1:0], 16'h0040, 18'h00000, 2'h0);
      issue(bmp_pkg::OP_MASK, p[1:0], 16'h00ff, 18'h00000, 2'h0);
      rdback(p[1:0], 16'h0040);
      issue(bmp_pkg::OP_CLEAR, p[1:0], 16'h0077, 18'h00000, 2'h0);
      rdback(p[1:0], 16'h0000);
      n = wraps[p];
      m = pulses[p];
      issue(bmp_pkg::OP_LOAD, p[1:0], 16'hffff, 18'h00000, 2'h0);
      issue(bmp_pkg::OP_STEP, p[1:0], 16'h0000, 18'h00000, 2'h0);
      rdback(p[1:0], 16'h0000);
      chk_cnt(16'(wraps[p] - n), 16'h0001);
      chk_cnt(16'(pulses[p] - m), 16'h0001);
    end
    chk_cnt(bmp_dev_end_i.g_port[0].mask_r, 16'h00ff);
    chk_cnt(bmp_dev_end_i.g_port[1].mask_r, 16'h00ff);
    chk_cnt(bmp_dev_end_i.g_port[2].mask_r, 16'h00ff);
    chk_cnt(bmp_dev_end_i.g_port[3].mask_r, 16'h00ff);
    $display("test mask clear wrap done");
    issue(bmp_pkg::OP_LOAD, 2'h2, 16'h0055, 18'h00000, 2'h0);
    repeat (4) @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rdback(2'h2, 16'h0000);
    chk_cnt(16'(gcnt), 16'(2 * bmp_pkg::HOST_RST_CYCLES));
    $display("test mid-run reset done");
    summarize();
  end
endmodule // test_burst_memory_port_control
